// >>> rtl/xfer_mult_pkg.sv
// Constants and types for the status-transfer and multiply execution block.
// Assumes one core clock and an Avalon-MM register slave in front of it.
// Summary of operation
// [RULE_01] Status word keeps flags, masks, state, mode.
// [RULE_02] Flag-only write copies top four bits.
// [RULE_03] User mode writes only the flag nibble.
// [RULE_04] Privileged whole write replaces whole word.
// [RULE_05] Status read copies full word to register.
// [RULE_06] Status transfers finish in one cycle.
// [RULE_07] Execute only when condition field passes.
// [RULE_08] Multiply fields: accumulate, flags, register numbers.
// [RULE_09] Plain multiply ignores the addend register.
// [RULE_10] Accumulate form adds the addend register.
// [RULE_11] One datapath gives low product bits.
// [RULE_12] Multiplier consumed eight bits per iteration.
// [RULE_13] Short multiply flags: N bit31, Z zero.
// [RULE_14] Short multiply takes one plus m cycles; the accumulate form here takes m+2.
// [RULE_15] Long product split into high, low destinations.
// [RULE_16] Long forms unsigned or two's complement.
// [RULE_17] Long multiply flags: N bit63, Z zero.
// [RULE_18] Long multiply takes m+1 or m+2 extra.
// [RULE_19] Iteration count from multiplier top bytes.
// [RULE_20] Software avoids PC and overlapping registers.
// [RULE_21] Address is base plus or minus offset.
// [RULE_22] Load/store control bits and immediate offset.
// [RULE_23] Undefined carry is forced to zero.
package xfer_mult_pkg;
    // Byte offsets of the register map, one aligned word each.
    localparam logic [7:0]  REG_GPR0  = 8'h00; // 16 general registers.
    localparam logic [7:0]  REG_INSTR = 8'h40; // Writing starts execution.
    localparam logic [7:0]  REG_CUR   = 8'h44; // Current status word.
    localparam logic [7:0]  REG_SAVED = 8'h48; // Saved word of this mode.
    localparam logic [7:0]  REG_STAT  = 8'h4c; // Busy, ran, cycle count.
    localparam logic [7:0]  REG_ADDR  = 8'h50; // Last transfer address.
    localparam logic [7:0]  REG_XFER  = 8'h54; // Last transfer controls.
    // Values after reset.
    localparam logic [31:0] CUR_RESET = 32'h0000_00d3;
    localparam logic [11:0] SAVED_RESET = 12'h000;
    localparam logic [7:0]  CYC_RESET = 8'h00;
    // Instruction field positions.
    localparam int COND_HI = 31;
    localparam int COND_LO = 28;
    localparam int B_IMM   = 25; // Immediate select.
    localparam int B_PRE   = 24; // Pre-index.
    localparam int B_UP    = 23; // Add offset.
    localparam int B_SEL   = 22; // Signed, byte, or saved word select.
    localparam int B_ACC   = 21; // Accumulate, or write-back.
    localparam int B_SET   = 20; // Flag update, or load.
    localparam int B_WHOLE = 16; // Whole-word status write.
    localparam int BANKS   = 5;  // Privileged modes that own a saved word.
    // Defined status bits only; reserved bits are not stored.
    typedef struct packed {
        logic       n;
        logic       z;
        logic       c;
        logic       v;
        logic       i;
        logic       f;
        logic       t;
        logic [4:0] mode;
    } psr_t;
    // Processor mode encodings.
    typedef enum logic [4:0] {
        MODE_USR = 5'h10, MODE_FIQ = 5'h11, MODE_IRQ = 5'h12,
        MODE_SVC = 5'h13, MODE_ABT = 5'h17, MODE_UND = 5'h1b,
        MODE_SYS = 5'h1f
    } mode_t;
    // Execution sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_DEC = 2'b01, ST_ITER = 2'b10, ST_ACC = 2'b11
    } state_t;
endpackage

// >>> rtl/mult_byte_step.sv
// One multiplier iteration: adds multiplicand times one multiplier byte.
// Assumes the caller sequences byte index and accumulates the sum.
module mult_byte_step
    import xfer_mult_pkg::*;
(
    input  wire logic [63:0] acc,
    input  wire logic [63:0] mcand,
    input  wire logic [7:0]  mbyte,
    input  wire logic        topSigned,
    input  wire logic [1:0]  idx,
    output logic      [63:0] sum
);
    logic [63:0] byteExt; // Byte widened; a set sign flag weighs -256.
    logic [63:0] part;    // Partial product before weighting.
    // The last byte is a nine-bit digit whose ninth bit is the operand's
    // sign, so an early stop on a run of ones above it stays exact.
    always_comb begin
        byteExt = {{56{topSigned}}, mbyte};
        part    = mcand * byteExt;
        sum     = acc + (part << {idx, 3'b000});
    end
endmodule // mult_byte_step

// >>> rtl/status_xfer_multiply_exec.sv
// Execution datapath for status transfers, multiplies and address forming.
// Assumes an Avalon-MM master on the core clock; writes stall while busy.
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
module status_xfer_multiply_exec
    import xfer_mult_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest
);
    // Evaluates a four-bit condition field against the flags.
    function automatic logic condPass(input logic [3:0] cc, input psr_t p);
        logic r;
        case (cc)
            4'h0: r = p.z;
            4'h1: r = ~p.z;
            4'h2: r = p.c;
            4'h3: r = ~p.c;
            4'h4: r = p.n;
            4'h5: r = ~p.n;
            4'h6: r = p.v;
            4'h7: r = ~p.v;
            4'h8: r = p.c & ~p.z;
            4'h9: r = ~p.c | p.z;
            4'ha: r = p.n == p.v;
            4'hb: r = p.n != p.v;
            4'hc: r = ~p.z & (p.n == p.v);
            4'hd: r = p.z | (p.n != p.v);
            4'he: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Maps a mode to its saved-word bank; 7 means the mode has none.
    function automatic logic [2:0] bankOf(input logic [4:0] m);
        logic [2:0] r;
        case (m)
            MODE_FIQ: r = 3'h0;
            MODE_IRQ: r = 3'h1;
            MODE_SVC: r = 3'h2;
            MODE_ABT: r = 3'h3;
            MODE_UND: r = 3'h4;
            default:  r = 3'h7;
        endcase
        return r;
    endfunction

    // [RULE_19] Early termination test.
    function automatic logic [1:0] lastStep(input logic [31:0] rs,
                                            input logic sg);
        logic [1:0] r;
        if (rs[31:8] == 24'h0 || (sg && &rs[31:8])) begin
            r = 2'h0;
        end else if (rs[31:16] == 16'h0 || (sg && &rs[31:16])) begin
            r = 2'h1;
        end else if (rs[31:24] == 8'h0 || (sg && &rs[31:24])) begin
            r = 2'h2;
        end else begin
            r = 2'h3;
        end
        return r;
    endfunction

    // [RULE_01] Reserved bits read zero.
    function automatic logic [31:0] psrWord(input psr_t p);
        return {p.n, p.z, p.c, p.v, 20'h0, p.i, p.f, p.t, p.mode};
    endfunction

    logic [31:0] gpr_q [16];        // General registers.
    psr_t        cur_q;             // Current status word.
    psr_t        saved_q [BANKS];   // Saved words, one per bank.
    state_t      state_q;           // Sequencer state.
    logic [31:0] instr_q;           // Instruction being executed.
    logic [63:0] acc_q;             // Running product plus addend.
    logic [63:0] mcand_q;           // Widened multiplicand.
    logic [31:0] mplier_q;          // Multiplier operand.
    logic [1:0]  step_q;            // Current byte index.
    logic [1:0]  lastStep_q;        // Final byte index, m - 1.
    logic [1:0]  extra_q;           // Remaining internal cycles.
    logic [1:0]  extraAll_q;        // Internal cycles beyond m.
    logic        topSigned_q;       // Top byte taken as signed.
    logic        long_q;            // Long form in flight.
    logic        setFl_q;           // Flag update requested.
    logic [3:0]  dLo_q;             // Low (or only) destination.
    logic [3:0]  dHi_q;             // High destination.
    logic [7:0]  cyc_q;             // Cycles spent so far.
    logic [7:0]  lastCyc_q;         // Cycles of the last instruction.
    logic        ran_q;             // Last instruction executed.
    logic [31:0] memAddr_q;         // Last load/store address.
    logic [5:0]  xfer_q;            // Last load/store control bits.
    logic        waitReq_q;         // Bus wait state.
    logic [31:0] rdata_q;           // Bus read data.

    assign readdata    = rdata_q;
    assign waitrequest = waitReq_q;

    // Decode views of the held instruction.
    logic [31:0] ins;
    logic        isMul, isLong, isMulAny, isMrs, isMsr, isLdSt, pass;
    logic        busy, useSaved, hasBank, isUser, onlyTop, sgn;
    logic [2:0]  bank;
    logic [31:0] curWord, savedWord, immWord, msrSrc, base, off, modAddr;
    logic [63:0] rotTmp, mcandExt, addend, stepSum, finVal;
    logic [11:0] newPsr;
    logic [1:0]  extraInit;
    logic        lastIter, finish, leaving;

    assign ins = instr_q;
    // [RULE_08] Multiply form recognition.
    assign isMul    = ins[27:22] == 6'h00 && ins[7:4] == 4'h9;
    assign isLong   = ins[27:23] == 5'h01 && ins[7:4] == 4'h9;
    assign isMulAny = isMul | isLong;
    assign isMrs    = ins[27:23] == 5'h02 && ins[21:16] == 6'h0f;
    assign isMsr    = ins[27:26] == 2'b00 && ins[24:23] == 2'b10
                      && ins[21:17] == 5'h14 && ins[15:12] == 4'hf;
    assign isLdSt   = ins[27:26] == 2'b01;
    // [RULE_07] Condition gate.
    assign pass     = condPass(ins[COND_HI:COND_LO], cur_q);
    assign busy     = state_q != ST_IDLE;
    assign useSaved = ins[B_SEL];
    assign bank     = bankOf(cur_q.mode);
    assign hasBank  = bank != 3'h7;
    assign isUser   = cur_q.mode == MODE_USR;
    assign curWord  = psrWord(cur_q);
    assign savedWord = hasBank ? psrWord(saved_q[bank]) : 32'h0;

    // Status write source: rotated immediate or a register.
    assign immWord = {24'h0, ins[7:0]};
    assign rotTmp  = {immWord, immWord} >> {ins[11:8], 1'b0};
    assign msrSrc  = ins[B_IMM] ? rotTmp[31:0] : gpr_q[ins[3:0]];
    // [RULE_03] User mode keeps control bits.
    assign onlyTop = ~ins[B_WHOLE] | (isUser & ~useSaved);
    // [RULE_02] Flag nibble copy, control kept.
    always_comb begin
        newPsr = useSaved ? saved_q[bank[2:0] == 3'h7 ? 3'h0 : bank]
                          : cur_q;
        newPsr[11:8] = msrSrc[31:28];
        // [RULE_04] Whole defined word replaced.
        if (!onlyTop) begin
            newPsr[7:0] = msrSrc[7:0];
        end
    end

    // [RULE_21] Base plus or minus offset.
    // [RULE_22] Immediate offset is unsigned 12 bits.
    assign base    = gpr_q[ins[19:16]];
    assign off     = ins[B_IMM] ? gpr_q[ins[3:0]] : {20'h0, ins[11:0]};
    assign modAddr = ins[B_UP] ? base + off : base - off;

    // [RULE_11] Short form runs signed; low bits agree either way.
    // [RULE_16] Long forms pick signedness from the select bit.
    assign sgn      = isLong ? ins[B_SEL] : 1'b1;
    assign mcandExt = sgn ? {{32{gpr_q[ins[3:0]][31]}}, gpr_q[ins[3:0]]}
                          : {32'h0, gpr_q[ins[3:0]]};
    // [RULE_09] Plain forms start from zero.
    // [RULE_10] Accumulate forms start from the addend.
    always_comb begin
        addend = 64'h0;
        if (ins[B_ACC] && isLong) begin
            addend = {gpr_q[ins[19:16]], gpr_q[ins[15:12]]};
        end else if (ins[B_ACC]) begin
            addend = {32'h0, gpr_q[ins[15:12]]};
        end
    end
    // [RULE_14] Short internal cycles beyond m.
    // [RULE_18] Long internal cycles beyond m.
    assign extraInit = isLong ? (ins[B_ACC] ? 2'h2 : 2'h1)
                              : (ins[B_ACC] ? 2'h1 : 2'h0);

    // [RULE_12] Eight multiplier bits per iteration.
    mult_byte_step uStep (
        .acc       (acc_q),
        .mcand     (mcand_q),
        .mbyte     (mplier_q[{step_q, 3'b000} +: 8]),
        .topSigned (topSigned_q & (step_q == lastStep_q) & mplier_q[31]),
        .idx       (step_q),
        .sum       (stepSum)
    );

    assign lastIter = state_q == ST_ITER && step_q == lastStep_q;
    assign finish   = (lastIter && extra_q == 2'h0)
                      || (state_q == ST_ACC && extra_q == 2'h1);
    assign finVal   = state_q == ST_ACC ? acc_q : stepSum;
    assign leaving  = (state_q == ST_DEC && !(pass && isMulAny)) || finish;

    // Bus handshake: one wait cycle, then one cycle with waitrequest low.
    logic accept, doWrite;
    assign accept  = waitReq_q & (read | (write & ~busy));
    assign doWrite = ~waitReq_q & write;

    // Wait state: low for exactly one cycle per accepted request.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            waitReq_q <= 1'b1;
        end else if (!waitReq_q) begin
            waitReq_q <= 1'b1;
        end else if (accept) begin
            waitReq_q <= 1'b0;
        end
    end

    // Read mux; unmapped or misaligned addresses read zero.
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0;
        if (address[1:0] != 2'b00) begin
            rdMux = 32'h0;
        end else if (address < REG_INSTR) begin
            rdMux = gpr_q[address[5:2]];
        end else begin
            case (address)
                REG_INSTR: rdMux = instr_q;
                REG_CUR:   rdMux = curWord;
                REG_SAVED: rdMux = savedWord;
                REG_STAT:  rdMux = {16'h0, lastCyc_q, 6'h0, ran_q, busy};
                REG_ADDR:  rdMux = memAddr_q;
                REG_XFER:  rdMux = {26'h0, xfer_q};
                default:   rdMux = 32'h0;
            endcase
        end
    end

    // Read data is captured at acceptance and stands while wait is low.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0;
        end else if (accept && read) begin
            rdata_q <= rdMux;
        end
    end

    // Instruction register; a write here starts the sequencer.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            instr_q <= 32'h0;
        end else if (doWrite && address == REG_INSTR) begin
            instr_q <= writedata;
        end
    end

    // Sequencer.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (doWrite && address == REG_INSTR) begin
                        state_q <= ST_DEC;
                    end
                end
                // [RULE_06] Non-multiplies finish here.
                ST_DEC: begin
                    state_q <= (pass && isMulAny) ? ST_ITER : ST_IDLE;
                end
                ST_ITER: begin
                    if (lastIter) begin
                        state_q <= extra_q == 2'h0 ? ST_IDLE : ST_ACC;
                    end
                end
                ST_ACC: begin
                    if (extra_q == 2'h1) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Multiply operands and iteration; loaded in the decode cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc_q       <= 64'h0;
            mcand_q     <= 64'h0;
            mplier_q    <= 32'h0;
            step_q      <= 2'h0;
            lastStep_q  <= 2'h0;
            extra_q     <= 2'h0;
            extraAll_q  <= 2'h0;
            topSigned_q <= 1'b0;
            long_q      <= 1'b0;
            setFl_q     <= 1'b0;
            dLo_q       <= 4'h0;
            dHi_q       <= 4'h0;
        end else if (state_q == ST_DEC) begin
            acc_q       <= addend;
            mcand_q     <= mcandExt;
            mplier_q    <= gpr_q[ins[11:8]];
            step_q      <= 2'h0;
            lastStep_q  <= lastStep(gpr_q[ins[11:8]], sgn);
            extra_q     <= extraInit;
            extraAll_q  <= extraInit;
            topSigned_q <= sgn;
            long_q      <= isLong;
            setFl_q     <= ins[B_SET];
            // [RULE_15] Long destinations high and low.
            dLo_q       <= isLong ? ins[15:12] : ins[19:16];
            dHi_q       <= ins[19:16];
        end else if (state_q == ST_ITER) begin
            acc_q  <= stepSum;
            step_q <= step_q + 2'h1;
        end else if (state_q == ST_ACC) begin
            extra_q <= extra_q - 2'h1;
        end
    end

    // General registers: bus writes while idle, results while busy.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int k = 0; k < 16; k++) begin
                gpr_q[k] <= 32'h0;
            end
        end else if (doWrite && address < REG_INSTR) begin
            gpr_q[address[5:2]] <= writedata;
        end else if (state_q == ST_DEC && pass) begin
            // [RULE_05] Whole status word to register.
            if (isMrs) begin
                gpr_q[ins[15:12]] <= useSaved ? savedWord : curWord;
            end else if (isLdSt && (ins[B_ACC] || !ins[B_PRE])) begin
                gpr_q[ins[19:16]] <= modAddr;
            end
        end else if (finish) begin
            gpr_q[dLo_q] <= finVal[31:0];
            if (long_q) begin
                gpr_q[dHi_q] <= finVal[63:32];
            end
        end
    end

    // Status words.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_q <= psr_t'({CUR_RESET[31:28], CUR_RESET[7:0]});
            for (int k = 0; k < BANKS; k++) begin
                saved_q[k] <= psr_t'(SAVED_RESET);
            end
        end else if (doWrite && address == REG_CUR) begin
            cur_q <= psr_t'({writedata[31:28], writedata[7:0]});
        end else if (doWrite && address == REG_SAVED && hasBank) begin
            saved_q[bank] <= psr_t'({writedata[31:28], writedata[7:0]});
        end else if (state_q == ST_DEC && pass && isMsr) begin
            if (!useSaved) begin
                cur_q <= psr_t'(newPsr);
            end else if (hasBank) begin
                saved_q[bank] <= psr_t'(newPsr);
            end
        end else if (finish && setFl_q) begin
            // [RULE_13] Short flags from bit 31.
            // [RULE_17] Long flags from bit 63.
            cur_q.n <= long_q ? finVal[63] : finVal[31];
            cur_q.z <= long_q ? finVal == 64'h0 : finVal[31:0] == 32'h0;
            // [RULE_23] Undefined carry made zero.
            cur_q.c <= 1'b0;
        end
    end

    // Cycle count, execution flag and transfer record.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cyc_q     <= CYC_RESET;
            lastCyc_q <= CYC_RESET;
            ran_q     <= 1'b0;
            memAddr_q <= 32'h0;
            xfer_q    <= 6'h0;
        end else begin
            cyc_q <= leaving ? CYC_RESET : (busy ? cyc_q + 8'h01 : cyc_q);
            if (leaving) begin
                lastCyc_q <= cyc_q + 8'h01;
            end
            if (state_q == ST_DEC) begin
                ran_q <= pass & (isMulAny | isMrs | isMsr | isLdSt);
            end
            if (state_q == ST_DEC && pass && isLdSt) begin
                memAddr_q <= ins[B_PRE] ? modAddr : base;
                xfer_q    <= ins[25:20];
            end
        end
    end

    logic [7:0] expCyc; // Expected total cycles of the multiply in flight.
    assign expCyc = {6'h0, lastStep_q} + {6'h0, extraAll_q} + 8'h02;

    // [RULE_01] Reserved bits read zero.
    reservedZero_a: assert property ( // [RULE_01]
        @(posedge clk) disable iff (!rstn)
        (accept && read && address == REG_CUR) |=> rdata_q[27:8] == 20'h0)
        else $error("reserved status bits read non-zero");
    // [RULE_02] Flag nibble copied.
    flagCopy_a: assert property ( // [RULE_02]
        @(posedge clk) disable iff (!rstn)
        (state_q == ST_DEC && pass && isMsr && !useSaved && !ins[B_WHOLE])
        |=> cur_q[11:8] == $past(msrSrc[31:28])
            && cur_q[7:0] == $past(cur_q[7:0]))
        else $error("flag-only write wrong");
    // [RULE_03] User control bits kept.
    userProtect_a: assert property ( // [RULE_03]
        @(posedge clk) disable iff (!rstn)
        (state_q == ST_DEC && isMsr && isUser && !useSaved)
        |=> cur_q.mode == MODE_USR && $stable(cur_q[7:0]))
        else $error("user mode changed control bits");
    // [RULE_04] Whole write replaces word.
    wholeWrite_a: assert property ( // [RULE_04]
        @(posedge clk) disable iff (!rstn)
        (state_q == ST_DEC && pass && isMsr && !isUser && !useSaved
         && ins[B_WHOLE])
        |=> curWord == ($past(msrSrc) & 32'hf000_00ff))
        else $error("whole status write wrong");
    // [RULE_06] One cycle for status transfers.
    statusCycle_a: assert property ( // [RULE_06]
        @(posedge clk) disable iff (!rstn)
        (state_q == ST_DEC && (isMrs || isMsr))
        |=> state_q == ST_IDLE && lastCyc_q == 8'h01)
        else $error("status transfer not one cycle");
    // [RULE_07] Failed condition changes nothing.
    condSkip_a: assert property ( // [RULE_07]
        @(posedge clk) disable iff (!rstn)
        (state_q == ST_DEC && !pass)
        |=> state_q == ST_IDLE && $stable(cur_q) && !ran_q)
        else $error("instruction ran on failed condition");
    // [RULE_14] Multiply cycle count.
    multCycles_a: assert property ( // [RULE_14]
        @(posedge clk) disable iff (!rstn)
        finish |=> lastCyc_q == $past(expCyc) && state_q == ST_IDLE)
        else $error("multiply cycle count wrong");
    // [RULE_13] Short multiply flags.
    mulFlags_a: assert property ( // [RULE_13]
        @(posedge clk) disable iff (!rstn)
        (finish && setFl_q && !long_q)
        |=> cur_q.n == $past(finVal[31])
            && cur_q.z == ($past(finVal[31:0]) == 32'h0)
            && $stable(cur_q.v))
        else $error("multiply flags wrong");
    // [RULE_21] Pre-indexed address.
    ldstAddr_a: assert property ( // [RULE_21]
        @(posedge clk) disable iff (!rstn)
        (state_q == ST_DEC && pass && isLdSt && ins[B_PRE])
        |=> memAddr_q == $past(modAddr))
        else $error("transfer address wrong");
endmodule // status_xfer_multiply_exec

// >>> verification/tb_top.sv
// Bench for the execution block: runs instructions over the register bus.
// Assumes the block's package map and its one-cycle bus answer.
module tb_top
    import xfer_mult_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;          // Core clock.
    logic        rstn = 1'b0;         // Reset, active low.
    logic [7:0]  address = 8'h00;     // Bus address.
    logic        read = 1'b0;         // Bus read request.
    logic        write = 1'b0;        // Bus write request.
    logic [31:0] writedata = 32'h0;   // Bus write data.
    logic [31:0] readdata;            // Bus read data.
    logic        waitrequest;         // Bus stall.
    logic [31:0] rdVal;               // Last word taken from the bus.
    int          error_cnt = 0;       // Mismatches.
    int          cmp_count = 0;       // Comparisons.
    // The clock toggles every half period of 5 ns.
    always #5 clk = ~clk;
    status_xfer_multiply_exec status_xfer_multiply_exec_inst (
        .clk(clk), .rstn(rstn), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest));
    // Prints the counts and the verdict, then stops.
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Compares one word; unknown bits never match.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One bus cycle; held until waitrequest is seen low at an edge.
    // An idle edge follows so no strobe is set twice in one step.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 100);
        rdVal = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0) begin
            error_cnt++;
            wrap_up();
        end
        @(posedge clk);
    endtask
    // Reads a register and compares it.
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdVal, exp);
    endtask
    // Starts an instruction, polls busy, then checks the busy, ran and cycle-count word.
    task automatic ex(input logic [31:0] ins, input logic [31:0] st);
        int n = 0;
        bus(1'b1, REG_INSTR, ins);
        do begin
            bus(1'b0, REG_STAT, 32'h0);
            n++;
        end while (rdVal[0] !== 1'b0 && n < 50);
        if (rdVal[0] !== 1'b0) begin
            error_cnt++;
            wrap_up();
        end
        chk(rdVal, st);
    endtask
    // Main sequence; the status figure holds ran flag and cycle count.
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rc(REG_CUR, CUR_RESET);
        rc(8'h58, 32'h0);
        bus(1'b1, 8'h08, 32'hffff_fff6);
        bus(1'b1, 8'h0c, 32'h0000_0014);
        bus(1'b1, 8'h10, 32'h0000_0200);
        ex(32'he001_4392, 32'h0000_0202);
        rc(8'h04, 32'hffff_ff38);
        ex(32'he035_4392, 32'h0000_0302);
        rc(8'h14, 32'h0000_0138);
        ex(32'he087_6392, 32'h0000_0302);
        rc(8'h1c, 32'h0000_0013);
        rc(8'h18, 32'hffff_ff38);
        ex(32'he0d7_6392, 32'h0000_0302);
        rc(8'h1c, 32'hffff_ffff);
        rc(REG_CUR, 32'h8000_00d3);
        // Signed early stop on a run of ones, then unsigned two-byte run.
        bus(1'b1, 8'h24, 32'hffff_ff05);
        ex(32'he01d_0992, 32'h0000_0202);
        rc(8'h34, 32'h0000_09ce);
        rc(REG_CUR, 32'h0000_00d3);
        ex(32'he0a7_6492, 32'h0000_0502);
        rc(8'h1c, 32'h0000_01ff);
        rc(8'h18, 32'hffff_eb38);
        $display("test multiply done");
        bus(1'b1, 8'h20, 32'h5fff_ffff);
        ex(32'he128_f008, 32'h0000_0102);
        rc(REG_CUR, 32'h5000_00d3);
        bus(1'b1, 8'h20, 32'h0fff_ff90);
        ex(32'he129_f008, 32'h0000_0102);
        bus(1'b1, 8'h20, 32'ha000_00d3);
        ex(32'he129_f008, 32'h0000_0102);
        ex(32'he10f_a000, 32'h0000_0102);
        rc(8'h28, 32'ha000_0090);
        ex(32'h0001_4392, 32'h0000_0100);
        rc(8'h04, 32'hffff_ff38);
        $display("test status done");
        bus(1'b1, 8'h30, 32'h0000_1000);
        ex(32'he5bc_b010, 32'h0000_0102);
        rc(REG_ADDR, 32'h0000_1010);
        rc(REG_XFER, 32'h0000_001b);
        ex(32'he40c_b004, 32'h0000_0102);
        rc(8'h30, 32'h0000_100c);
        $display("test transfer done");
        wrap_up();
    end
endmodule // tb_top
